// [rtl/ebt_pkg.sv]
// Constants for the external bus acknowledge-termination block.
// Assumes a single system bus clock; all counts are in clock cycles.
`default_nettype none

package ebt_pkg;
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned TIMEOUT_CYCLES = 1024;
    localparam int unsigned TMO_W = 11;
    localparam logic [TMO_W-1:0] TMO_LIMIT = TMO_W'(TIMEOUT_CYCLES);
    localparam logic [TMO_W-1:0] TMO_RESET = 11'h000;
    localparam int unsigned WSC_W = 6;
    localparam int unsigned DLY_W = 4;
    localparam int unsigned HOLD_W = 2;
    localparam int unsigned CS_W = 3;
    localparam logic [CS_W-1:0] EDGE_CS = 3'h5;
    localparam logic [CS_W-1:0] SHARED_ACK_CS = 3'h4;
    localparam logic [WSC_W-1:0] HOLDOFF_MIN = 6'h02;
    localparam logic [WSC_W-1:0] HOLDOFF_MAX = 6'h05;
    localparam logic [WSC_W-1:0] CNT_ZERO = 6'h00;
    localparam logic [WSC_W-1:0] CNT_ONE = 6'h01;

    typedef enum logic [1:0] {
        MODE_PLAIN,
        MODE_EDGE,
        MODE_LEVEL
    } ebt_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ASSERT,
        ST_HOLD,
        ST_ACCESS,
        ST_NEGATE
    } ebt_state_t;
endpackage : ebt_pkg

`default_nettype wire

// [rtl/ebt_watchdog.sv]
// Bus time-out monitor counting system clock cycles of one external cycle.
// Assumes clear_in is pulsed when a cycle starts.
`default_nettype none

module ebt_watchdog
(
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic clear_in,
    input wire logic run_in,
    output logic expired_out
);
    import ebt_pkg::*;

    logic [TMO_W-1:0] count_ff;

    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            count_ff <= TMO_RESET;
        end
        else if (clear_in)
        begin
            count_ff <= TMO_RESET;
        end
        else if (run_in && (count_ff != TMO_LIMIT))
        begin
            count_ff <= count_ff + TMO_W'(1);
        end
    end

    // Saturates so the flag holds until the next clear
    assign expired_out = (count_ff == TMO_LIMIT); // see [RQ1]
endmodule // ebt_watchdog

`default_nettype wire

// [rtl/ebt_ack_term.sv]
// Acknowledge-termination sequencer for one external asynchronous bus cycle.
// Assumes configuration ports are stable while busy_out is high.
//
// Function
// [RQ1] With acknowledge enabled, unterminated cycle raises bus error after 1024 clocks.
// [RQ2] Acknowledge sensed either by rising edge or by level after hold-off.
// [RQ3] Software uses acknowledge only with synchronous burst selection cleared.
// [RQ4] Edge mode ends the transfer on an acknowledge rising edge before time-out.
// [RQ5] Edge mode is available only on chip select five.
// [RQ6] Software sets wait count 0x3F, select delay at least 1, edge bit.
// [RQ7] Nonzero select delay lets edges be caught between back-to-back transfers.
// [RQ8] Level mode ignores acknowledge for two to five clocks per hold-off field.
// [RQ9] After hold-off, high proceeds with wait states, low stalls until high.
// [RQ10] In level mode, acknowledge low anytime suspends transfer until high again.
// [RQ11] Level mode works on every chip select except number four.
// [RQ12] Software sets wait enable, wait count above 1, negate delay below 3.
// [RQ13] Software picks hold-off value to suit the attached device.
// [RQ14] On time-out, abort cycle, drop select and strobe, return error.
`default_nettype none

module ebt_ack_term
(
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic start_in,
    input wire logic [ebt_pkg::CS_W-1:0] cs_index_in,
    input wire logic ack_edge_mode_in,
    input wire logic ext_wait_enable_in,
    input wire logic sync_burst_in,
    input wire logic [ebt_pkg::WSC_W-1:0] wait_state_count_in,
    input wire logic [ebt_pkg::DLY_W-1:0] select_assert_delay_in,
    input wire logic [ebt_pkg::DLY_W-1:0] select_negate_delay_in,
    input wire logic [ebt_pkg::HOLD_W-1:0] ack_holdoff_count_in,
    input wire logic transfer_ack_in,
    output logic busy_out,
    output logic select_out,
    output logic strobe_out,
    output logic stalled_out,
    output logic done_out,
    output logic bus_error_out
);
    import ebt_pkg::*;

    ebt_state_t state_ff;
    ebt_state_t nxt_state;
    ebt_mode_t mode_ff;
    ebt_mode_t nxt_mode;
    logic [WSC_W-1:0] cnt_ff;
    logic [WSC_W-1:0] nxt_cnt;
    logic [DLY_W-1:0] negate_ff;
    logic ack_prev_ff;
    logic edge_seen_ff;
    logic busy_ff;
    logic select_ff;
    logic strobe_ff;
    logic stalled_ff;
    logic done_ff;
    logic error_ff;
    logic rise;
    logic expired;
    logic finish;
    logic abort;
    logic take;

    assign take = start_in && (state_ff == ST_IDLE);
    assign rise = transfer_ack_in && !ack_prev_ff;

    // Synchronous burst cycles never use acknowledge termination
    always_comb
    begin
        nxt_mode = MODE_PLAIN;
        if (!sync_burst_in) // see [RQ3]
        begin
            if (ack_edge_mode_in && (cs_index_in == EDGE_CS)) // see [RQ5]
            begin
                nxt_mode = MODE_EDGE;
            end
            else if (!ack_edge_mode_in && ext_wait_enable_in && (cs_index_in != SHARED_ACK_CS)) // see [RQ11]
            begin
                nxt_mode = MODE_LEVEL;
            end
        end
    end

    ebt_watchdog u_watchdog
    (
        .core_clk_in(core_clk_in),
        .arst_n_in(arst_n_in),
        .clear_in(take),
        .run_in((state_ff != ST_IDLE) && (state_ff != ST_NEGATE) && (mode_ff != MODE_PLAIN)), // see [RQ1]
        .expired_out(expired)
    );

    // Completion of the data phase; an edge during the assert delay counts too
    always_comb
    begin
        finish = 1'b0;
        if (state_ff == ST_ACCESS)
        begin
            case (mode_ff)
                MODE_EDGE: finish = edge_seen_ff || rise; // see [RQ4]
                MODE_LEVEL: finish = transfer_ack_in && (cnt_ff == CNT_ZERO); // see [RQ9]
                MODE_PLAIN: finish = (cnt_ff == CNT_ZERO);
                default: finish = 1'b0;
            endcase
        end
    end

    // Completion in the expiry cycle still counts as terminated
    assign abort = expired && !finish && (state_ff != ST_IDLE) && (state_ff != ST_NEGATE); // see [RQ14]

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (take)
                begin
                    nxt_state = ST_ASSERT;
                    nxt_cnt = WSC_W'(select_assert_delay_in);
                    if (select_assert_delay_in == 4'h0)
                    begin
                        nxt_state = (nxt_mode == MODE_LEVEL) ? ST_HOLD : ST_ACCESS;
                        nxt_cnt = (nxt_mode == MODE_LEVEL) ? (HOLDOFF_MIN + WSC_W'(ack_holdoff_count_in) - CNT_ONE)
                                                            : wait_state_count_in;
                    end
                end
            end
            ST_ASSERT:
            begin
                if (cnt_ff <= CNT_ONE)
                begin
                    nxt_state = (mode_ff == MODE_LEVEL) ? ST_HOLD : ST_ACCESS;
                    nxt_cnt = (mode_ff == MODE_LEVEL) ? (HOLDOFF_MIN + WSC_W'(ack_holdoff_count_in) - CNT_ONE)
                                                      : wait_state_count_in;
                end
                else
                begin
                    nxt_cnt = cnt_ff - CNT_ONE;
                end
            end
            ST_HOLD:
            begin
                // Acknowledge is not looked at here at all
                if (cnt_ff == CNT_ZERO) // see [RQ8]
                begin
                    nxt_state = ST_ACCESS;
                    nxt_cnt = wait_state_count_in;
                end
                else
                begin
                    nxt_cnt = cnt_ff - CNT_ONE;
                end
            end
            ST_ACCESS:
            begin
                if (finish)
                begin
                    nxt_state = (negate_ff == 4'h0) ? ST_IDLE : ST_NEGATE;
                    nxt_cnt = WSC_W'(negate_ff);
                end
                else if ((mode_ff != MODE_EDGE) && (cnt_ff != CNT_ZERO))
                begin
                    // In level mode, low acknowledge freezes the wait-state count
                    if ((mode_ff != MODE_LEVEL) || transfer_ack_in) // see [RQ10]
                    begin
                        nxt_cnt = cnt_ff - CNT_ONE;
                    end
                end
            end
            ST_NEGATE:
            begin
                if (cnt_ff <= CNT_ONE)
                begin
                    nxt_state = ST_IDLE;
                end
                nxt_cnt = cnt_ff - CNT_ONE;
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
        if (abort)
        begin
            nxt_state = ST_IDLE; // see [RQ14]
            nxt_cnt = CNT_ZERO;
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state_ff <= ST_IDLE;
            cnt_ff <= CNT_ZERO;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            mode_ff <= MODE_PLAIN;
            negate_ff <= 4'h0;
        end
        else if (take)
        begin
            mode_ff <= nxt_mode; // see [RQ2]
            negate_ff <= select_negate_delay_in;
        end
    end

    // Edge history runs between cycles so a rise during a select delay is kept
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            ack_prev_ff <= 1'b1;
            edge_seen_ff <= 1'b0;
        end
        else
        begin
            ack_prev_ff <= transfer_ack_in;
            if (take)
            begin
                edge_seen_ff <= 1'b0;
            end
            else if (rise && (state_ff == ST_ASSERT)) // see [RQ7]
            begin
                edge_seen_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            busy_ff <= 1'b0;
            select_ff <= 1'b0;
            strobe_ff <= 1'b0;
            stalled_ff <= 1'b0;
        end
        else
        begin
            busy_ff <= (nxt_state != ST_IDLE);
            select_ff <= (nxt_state != ST_IDLE);
            strobe_ff <= (nxt_state == ST_HOLD) || (nxt_state == ST_ACCESS);
            // Mode is stale in the taking cycle; level cycles never reach access straight from idle
            stalled_ff <= (nxt_state == ST_ACCESS) && (state_ff != ST_IDLE) && (mode_ff == MODE_LEVEL)
                          && !transfer_ack_in; // see [RQ10]
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            done_ff <= 1'b0;
            error_ff <= 1'b0;
        end
        else
        begin
            done_ff <= finish;
            error_ff <= abort; // see [RQ1]
        end
    end

    assign busy_out = busy_ff;
    assign select_out = select_ff;
    assign strobe_out = strobe_ff;
    assign stalled_out = stalled_ff;
    assign done_out = done_ff;
    assign bus_error_out = error_ff;
endmodule // ebt_ack_term

`default_nettype wire

// [tb/ebt_ack_checker.sv]
// Port-level checks for the acknowledge-termination sequencer.
// Assumes it is bound to ebt_ack_term and sees only its ports.
`default_nettype none

module ebt_ack_checker
(
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic start_in,
    input wire logic busy_out,
    input wire logic select_out,
    input wire logic strobe_out,
    input wire logic stalled_out,
    input wire logic done_out,
    input wire logic bus_error_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [10:0] run_ff;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);
    // Saturates so a hung cycle still trips the bound below
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            run_ff <= 11'h000;
        else if (!busy_out)
            run_ff <= 11'h000;
        else if (run_ff != 11'h7ff)
            run_ff <= run_ff + 11'h001;
    end
    a_select_tracks_busy: assert property (select_out == busy_out)
        else $error("select differs from busy");
    a_strobe_in_select: assert property (strobe_out |-> select_out)
        else $error("strobe without select");
    a_error_drops_all: assert property (bus_error_out |-> !busy_out && !strobe_out)
        else $error("abort left select");
    a_end_one_kind: assert property (!(done_out && bus_error_out))
        else $error("done and error together");
    a_done_one_pulse: assert property (done_out |=> !done_out)
        else $error("done longer than a cycle");
    a_done_not_stalled: assert property (done_out |-> !stalled_out)
        else $error("done while stalled");
    a_stall_in_data: assert property (stalled_out |-> strobe_out)
        else $error("stall outside data phase");
    a_take_starts: assert property (start_in && !busy_out |=> busy_out)
        else $error("request not taken");
    a_wait_bounded: assert property (busy_out |-> run_ff < 11'h440)
        else $error("cycle never ended");
    a_error_late: assert property (bus_error_out |-> $past(run_ff) > 11'h3fb && $past(run_ff) < 11'h407)
        else $error("time-out at wrong count");
endmodule // ebt_ack_checker

bind ebt_ack_term ebt_ack_checker chk_u (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .start_in(start_in),
    .busy_out(busy_out), .select_out(select_out), .strobe_out(strobe_out), .stalled_out(stalled_out),
    .done_out(done_out), .bus_error_out(bus_error_out));

`default_nettype wire

// [tb/ebt_slow_device.sv]
// Model of an external asynchronous device answering on the acknowledge line.
// Assumes select_in is the sequencer's registered chip select.
`default_nettype none

module ebt_slow_device
(
    input wire logic core_clk_in,
    input wire logic select_in,
    input wire logic [11:0] rise_in,
    input wire logic [11:0] gap_at_in,
    input wire logic [11:0] gap_len_in,
    output logic transfer_ack_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] age_ff;
    logic in_gap;
    always_ff @(posedge core_clk_in)
    begin
        age_ff <= select_in ? age_ff + 12'h001 : 12'h000;
    end
    // Pull-up keeps the line high while deselected; with rise_in nonzero each access pulls it low and it rises again at age rise_in
    always_comb
    begin
        in_gap = (age_ff >= gap_at_in) && (age_ff < gap_at_in + gap_len_in);
        transfer_ack_out = !select_in || ((age_ff >= rise_in) && !in_gap);
    end
endmodule // ebt_slow_device

`default_nettype wire

// [tb/external_bus_ack_termination_test.sv]
// Self-checking bench for the acknowledge-termination sequencer.
// Assumes the slow-device model drives the acknowledge line.
`default_nettype none

module external_bus_ack_termination_test;
    timeunit 1ns;
    timeprecision 1ps;
    import ebt_pkg::*;
    // Each row also gives the number of stalled cycles seen while waiting for the end
    typedef struct {
        logic [2:0] cs; logic edg; logic ew; logic sb; logic [5:0] wait_state_count; logic [3:0] a; logic [3:0] n;
        logic [1:0] hold; logic [11:0] rise; logic [11:0] gat; logic [11:0] glen; logic err; int lo; int hi; int st;
    } ebt_row_t;
    logic clk, rst_n, start, edg, ew, sb, ack, busy, sel, stb, stall, done, berr;
    logic [2:0] cs;
    logic [5:0] wait_state_count;
    logic [3:0] a, n;
    logic [1:0] hold;
    logic [11:0] rise, gat, glen;
    int err_total, checks, cyc;
    ebt_row_t rows [11];
    ebt_slow_device dev_u (.core_clk_in(clk), .select_in(sel), .rise_in(rise), .gap_at_in(gat), .gap_len_in(glen),
        .transfer_ack_out(ack));
    ebt_ack_term dut_u (.core_clk_in(clk), .arst_n_in(rst_n), .start_in(start), .cs_index_in(cs),
        .ack_edge_mode_in(edg), .ext_wait_enable_in(ew), .sync_burst_in(sb), .wait_state_count_in(wait_state_count),
        .select_assert_delay_in(a), .select_negate_delay_in(n), .ack_holdoff_count_in(hold),
        .transfer_ack_in(ack), .busy_out(busy), .select_out(sel), .strobe_out(stb), .stalled_out(stall),
        .done_out(done), .bus_error_out(berr));
    task automatic wrap_up();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Latency counts edges after the taking edge; a range absorbs the asynchronous answer time
    task automatic run_one(input ebt_row_t r);
        int lat;
        int st;
        lat = 0;
        st = 0;
        {cs, edg, ew, sb, wait_state_count, a, n, hold} = {r.cs, r.edg, r.ew, r.sb, r.wait_state_count, r.a, r.n, r.hold};
        {rise, gat, glen} = {r.rise, r.gat, r.glen};
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        while (done !== 1'b1 && berr !== 1'b1 && lat < 1100)
        begin
            if (stall === 1'b1)
                st++;
            @(negedge clk);
            lat++;
        end
        check(berr, r.err);
        check(lat, (lat < r.lo || lat > r.hi) ? r.lo : lat);
        check(st, r.st);
        repeat (20) if (busy !== 1'b0) @(negedge clk);
        check(busy, 1'b0);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            wrap_up();
        end
    end
    initial
    begin
        {rst_n, start, cs, edg, ew, sb, wait_state_count, a, n, hold, rise, gat, glen} = '0;
        // Plain cycles end one edge after the last wait state: assert delay plus wait count plus one
        rows = '{
        '{3'h1, 1'h0, 1'h0, 1'h1, 6'h03, 4'h1, 4'h0, 2'h0, 12'h0, 12'h0, 12'h0, 1'h0, 5, 5, 0},
        '{3'h3, 1'h1, 1'h0, 1'h0, 6'h02, 4'h0, 4'h0, 2'h0, 12'h0, 12'h0, 12'h0, 1'h0, 3, 3, 0},
        '{3'h4, 1'h0, 1'h1, 1'h0, 6'h02, 4'h1, 4'h0, 2'h0, 12'hfff, 12'h0, 12'h0, 1'h0, 4, 4, 0},
        '{3'h5, 1'h1, 1'h0, 1'h0, 6'h3f, 4'h1, 4'h1, 2'h0, 12'h6, 12'h0, 12'h0, 1'h0, 6, 12, 0},
        '{3'h5, 1'h1, 1'h0, 1'h0, 6'h3f, 4'h0, 4'h1, 2'h0, 12'h3, 12'h0, 12'h0, 1'h0, 3, 9, 0},
        '{3'h5, 1'h1, 1'h0, 1'h0, 6'h3f, 4'h1, 4'h1, 2'h0, 12'hfff, 12'h0, 12'h0, 1'h1, 1024, 1030, 0},
        '{3'h2, 1'h0, 1'h1, 1'h0, 6'h02, 4'h0, 4'h2, 2'h3, 12'h0, 12'h0, 12'h0, 1'h0, 8, 12, 0},
        '{3'h2, 1'h0, 1'h1, 1'h0, 6'h02, 4'h0, 4'h0, 2'h0, 12'h0, 12'h0, 12'h0, 1'h0, 4, 7, 0},
        '{3'h2, 1'h0, 1'h1, 1'h0, 6'h02, 4'h0, 4'h0, 2'h0, 12'h14, 12'h0, 12'h0, 1'h0, 20, 26, 19},
        '{3'h2, 1'h0, 1'h1, 1'h0, 6'h08, 4'h0, 4'h0, 2'h0, 12'h0, 12'h6, 12'ha, 1'h0, 19, 26, 10},
        '{3'h2, 1'h0, 1'h1, 1'h0, 6'h02, 4'h0, 4'h0, 2'h0, 12'hfff, 12'h0, 12'h0, 1'h1, 1024, 1030, 1023}
        };
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        foreach (rows[i])
        begin
            run_one(rows[i]);
            $display("test %0d finished", i);
        end
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        repeat (5) @(negedge clk);
        rst_n = 1'b0;
        #1;
        check({busy, sel, stb, stall, done, berr}, 6'h00);
        @(negedge clk);
        rst_n = 1'b1;
        run_one(rows[0]);
        $display("reset test finished");
        wrap_up();
    end
endmodule // external_bus_ack_termination_test

`default_nettype wire
